// File: hw/fcs_pkg.sv
/*
  Shared constants, types and register map of the flash command sequencer.
  Assumes one system clock and byte-wide command, data and register access.
*/
package fcs_pkg;

  // Flash array geometry: address bit 6 picks the area, 5:4 the block.
  localparam int FL_AW     = 7;
  localparam int OFS_W     = 4;
  localparam int BLK_BYTES = 16;
  localparam int FL_BYTES  = 128;

  // Command codes written in the first or second bus cycle.
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_PROGRAM     = 8'h40;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_LOCK_PROG   = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ   = 8'h71;
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h25;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;

  // Register offsets on the register port.
  localparam logic [1:0] REG_CTRL0  = 2'h0;
  localparam logic [1:0] REG_CTRL1  = 2'h1;
  localparam logic [1:0] REG_CTRL2  = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;

  // Control register 0 fields.
  localparam int C0_REWRITE_EN = 0;
  localparam int C0_EW_MODE_B  = 1;
  localparam int C0_FLASH_STOP = 2;
  localparam int C0_CMD_RESET  = 3;
  localparam int C0_READY_IE   = 7;
  // Control register 1 fields; block disables sit in bits 4 to 7.
  localparam int C1_LOCK_DIS   = 3;
  localparam int C1_BLK_DIS    = 4;
  // Control register 2 fields.
  localparam int C2_SUSP_EN    = 0;
  localparam int C2_SUSP_REQ   = 1;
  localparam int C2_SUSP_BY_IRQ = 2;
  // Status register fields.
  localparam int ST_LOCK_DATA  = 1;
  localparam int ST_PROG_ERR   = 4;
  localparam int ST_ERASE_ERR  = 5;
  localparam int ST_SUSPENDED  = 6;
  localparam int ST_READY      = 7;

  // Reset values.
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [3:0] LOCK_RST  = 4'hF;

  // Operation times in ns and their least cycle counts at 250 MHz.
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS  = 1000;
  localparam int ERASE_TIME_NS = 4000;
  localparam int LOCK_TIME_NS  = 400;
  localparam int BLANK_TIME_NS = 200;
  localparam logic [11:0] PROG_CYC =
    12'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ERASE_CYC =
    12'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] LOCK_CYC =
    12'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] BLANK_CYC =
    12'((BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PEND   = 3'b001,
    ST_PROG   = 3'b010,
    ST_ERASE  = 3'b011,
    ST_LOCKP  = 3'b100,
    ST_LOCKR  = 3'b101,
    ST_BLANK  = 3'b110,
    ST_SUSP   = 3'b111
  } fcs_state_e;

  // Flash-side access from the CPU.
  typedef struct packed {
    logic [FL_AW-1:0] addr;
    logic [7:0]       wdata;
    logic             wr;
    logic             rd;
  } fcs_fl_req_s;

  // Register port access.
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fcs_reg_req_s;

endpackage

// File: hw/fcs_sequencer.sv
/*
  Flash command sequencer: decodes byte commands, runs program, erase,
  lock and blank check operations on a small array, guards blocks.
  Assumes command writes and interrupt requests come from logic on
  i_sys_clk and that the CPU keeps to byte accesses and valid codes.
*/
// Summary of operation
// R01: Program ROM reads served during data flash busy.
// R02: Data flash reads refused during data flash busy.
// R03: Each program ROM block has lock bit.
// R04: Lock disable treats all blocks unlocked.
// R05: Lock cleared by command, set by erase.
// R06: Erase sets the block lock bit to one.
// R07: Lock disable cleared on listed events.
// R08: Host uses byte accesses and valid codes.
// R09: FFh enters and keeps read array mode.
// R10: Read array after reset and completions.
// R11: 50h clears both error bits.
// R12: 40h then data programs one byte.
// R13: Host repeats address, never reprograms unerased.
// R14: Ready low while busy, results in errors.
// R15: 20h then D0h erases block to FFh.
// R16: 77h, 71h, 25h two-cycle commands decoded.
// R17: Rewrite disable rejects data flash writes.
// R18: Locked program ROM blocks reject writes.
// R19: Ready interrupt on program or erase end.
// R20: Ready interrupt when erase actually suspends.
// R21: Interrupt sets suspend request during erase.
// R22: Software avoids rewriting its running code.
// R23: Sequence error sets both error bits.
// R24: First code held pending until next write.
`timescale 1ns/1ps
module fcs_sequencer (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire fcs_pkg::fcs_fl_req_s  i_fl_req,
  input  wire logic                i_irq_req,
  input  wire fcs_pkg::fcs_reg_req_s i_reg_req,
  output logic [7:0]               o_fl_rdata,
  output logic                     o_fl_rvalid,
  output logic                     o_fl_rerr,
  output logic [7:0]               o_reg_rdata,
  output logic                     o_ready_irq
);
  import fcs_pkg::*;

  localparam int PROG_BOUND = 260;

  fcs_state_e       state;
  fcs_state_e       next_state;
  fcs_state_e       rest_state;
  logic [7:0]       ctrl0;
  logic [7:0]       ctrl1;
  logic [7:0]       ctrl2;
  logic [7:0]       pend_cmd;
  logic [FL_AW-1:0] op_addr;
  logic [7:0]       op_data;
  logic [2:0]       erase_blk;
  logic [11:0]      op_cnt;
  logic [11:0]      erase_cnt;
  logic             susp_held;
  logic             prog_err;
  logic             erase_err;
  logic             lock_data;
  logic             ready_prev;
  logic [3:0]       lock_bits;
  logic [7:0]       mem [FL_BYTES];
  logic             abort;
  logic             ready_now;
  logic             susp_req_now;
  logic             ev_seq_err;
  logic             ev_clear;
  logic             ev_rej_prog;
  logic             ev_rej_erase;
  logic             ev_suspend;
  logic             ev_resume;
  logic             op_done;
  logic             erase_done;
  logic             blank_ok;
  logic             prog_ok;
  logic             rd_blocked;

  // Block index of an address: area bit and block number.
  function automatic logic [2:0] blk_of(input logic [FL_AW-1:0] a);
    blk_of = a[FL_AW-1:OFS_W];
  endfunction

  // True when a program or erase may not touch the addressed block.
  function automatic logic protected_blk(input logic [FL_AW-1:0] a,
                                         input logic [7:0] c1,
                                         input logic [3:0] lk);
    if (a[FL_AW-1]) begin
      protected_blk = c1[C1_BLK_DIS + 32'(a[5:4])];          // [R17]
    end else begin
      protected_blk = !c1[C1_LOCK_DIS] && !lk[a[5:4]];       // [R04] [R18]
    end
  endfunction

  // First-cycle codes of the two-cycle commands.
  function automatic logic is_first(input logic [7:0] d);
    is_first = (d == CMD_PROGRAM) || (d == CMD_ERASE) ||
               (d == CMD_LOCK_PROG) || (d == CMD_LOCK_READ) ||
               (d == CMD_BLANK_CHECK);                       // [R16]
  endfunction

  // Control signals that stop the command path at once.
  assign abort = !ctrl0[C0_REWRITE_EN] || ctrl0[C0_FLASH_STOP] ||
                 ctrl0[C0_CMD_RESET];
  assign ready_now = (state == ST_IDLE) || (state == ST_PEND) ||
                     (state == ST_SUSP);                     // [R14]
  assign susp_req_now = ctrl2[C2_SUSP_REQ] ||
                        (ctrl2[C2_SUSP_BY_IRQ] && i_irq_req);
  assign rest_state = susp_held ? ST_SUSP : ST_IDLE;
  assign op_done = (state == ST_PROG || state == ST_LOCKP ||
                    state == ST_LOCKR || state == ST_BLANK) &&
                   (op_cnt == 12'h001) && !abort;
  assign erase_done = (state == ST_ERASE) && (erase_cnt == 12'h001) &&
                      !abort;

  // Blank result over the target block and program verify result.
  always_comb begin
    blank_ok = 1'b1;
    for (int i = 0; i < BLK_BYTES; i++) begin
      if (mem[{blk_of(op_addr), 4'(i)}] != ERASED_BYTE) begin
        blank_ok = 1'b0;
      end
    end
    prog_ok = ((mem[op_addr] & op_data) == op_data);
  end

  // Command decoder and operation sequencing.
  always_comb begin
    next_state   = state;
    ev_seq_err   = 1'b0;
    ev_clear     = 1'b0;
    ev_rej_prog  = 1'b0;
    ev_rej_erase = 1'b0;
    ev_suspend   = 1'b0;
    ev_resume    = 1'b0;
    if (abort) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_IDLE, ST_SUSP: begin
          if (i_fl_req.wr) begin
            if (i_fl_req.wdata == CMD_READ_ARRAY) begin
              next_state = rest_state;                       // [R09]
            end else if (i_fl_req.wdata == CMD_CLEAR_STAT) begin
              ev_clear   = 1'b1;                             // [R11]
              next_state = rest_state;
            end else if (is_first(i_fl_req.wdata)) begin
              next_state = ST_PEND;                          // [R24]
            end else begin
              ev_seq_err = 1'b1;
              next_state = rest_state;
            end
          end else if (state == ST_SUSP && !ctrl2[C2_SUSP_REQ]) begin
            ev_resume  = 1'b1;
            next_state = ST_ERASE;
          end
        end
        ST_PEND: begin
          if (i_fl_req.wr) begin
            next_state = rest_state;
            if (pend_cmd == CMD_PROGRAM) begin
              if (susp_held && blk_of(i_fl_req.addr) == erase_blk) begin
                ev_seq_err = 1'b1;
              end else if (protected_blk(i_fl_req.addr, ctrl1,
                                         lock_bits)) begin
                ev_rej_prog = 1'b1;                          // [R17] [R18]
              end else begin
                next_state = ST_PROG;                        // [R12]
              end
            end else if (i_fl_req.wdata == CMD_READ_ARRAY) begin
              next_state = rest_state;
            end else if (i_fl_req.wdata != CMD_CONFIRM) begin
              ev_seq_err = 1'b1;                             // [R23]
            end else if (susp_held && (pend_cmd == CMD_ERASE ||
                         pend_cmd == CMD_BLANK_CHECK ||
                         blk_of(i_fl_req.addr) == erase_blk)) begin
              ev_seq_err = 1'b1;
            end else if (pend_cmd == CMD_ERASE) begin
              if (protected_blk(i_fl_req.addr, ctrl1, lock_bits)) begin
                ev_rej_erase = 1'b1;                         // [R17] [R18]
              end else begin
                next_state = ST_ERASE;                       // [R15]
              end
            end else if (pend_cmd == CMD_LOCK_PROG) begin
              next_state = ST_LOCKP;                         // [R16]
            end else if (pend_cmd == CMD_LOCK_READ) begin
              next_state = ST_LOCKR;
            end else begin
              next_state = ST_BLANK;
            end
          end
        end
        ST_ERASE: begin
          if (erase_done) begin
            next_state = ST_IDLE;                            // [R10]
          end else if (ctrl2[C2_SUSP_EN] && susp_req_now) begin
            ev_suspend = 1'b1;
            next_state = ST_SUSP;                            // [R10]
          end
        end
        default: begin
          if (op_done) begin
            next_state = rest_state;                         // [R10]
          end
        end
      endcase
    end
  end

  // State register; reset lands in read array mode.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;                                      // [R10]
    end else begin
      state <= next_state;
    end
  end

  // Pending code, operation target and cycle counters.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_cmd  <= 8'h00;
      op_addr   <= '0;
      op_data   <= 8'h00;
      op_cnt    <= 12'h000;
      erase_cnt <= 12'h000;
      erase_blk <= 3'h0;
    end else begin
      if (state != ST_PEND && next_state == ST_PEND) begin
        pend_cmd <= i_fl_req.wdata;                          // [R24]
      end
      if (state == ST_PEND && next_state != rest_state) begin
        op_addr <= i_fl_req.addr;
        op_data <= i_fl_req.wdata;
        case (next_state)
          ST_PROG:  op_cnt <= PROG_CYC;
          ST_LOCKP: op_cnt <= LOCK_CYC;
          ST_LOCKR: op_cnt <= LOCK_CYC;
          ST_BLANK: op_cnt <= BLANK_CYC;
          default: begin
            erase_cnt <= ERASE_CYC;
            erase_blk <= blk_of(i_fl_req.addr);
          end
        endcase
      end else if (op_cnt != 12'h000 && state != ST_ERASE) begin
        op_cnt <= op_cnt - 12'h001;
      end
      if (state == ST_ERASE && erase_cnt != 12'h000) begin
        erase_cnt <= erase_cnt - 12'h001;                    // Pauses in suspend.
      end
    end
  end

  // Suspended erase bookkeeping.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      susp_held <= 1'b0;
    end else if (abort || ev_resume) begin
      susp_held <= 1'b0;
    end else if (ev_suspend) begin
      susp_held <= 1'b1;
    end
  end

  // Error bits and lock status data; completions set, 50h clears the error bits only.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prog_err  <= 1'b0;
      erase_err <= 1'b0;
      lock_data <= 1'b0;
    end else begin
      if (ev_seq_err) begin
        prog_err  <= 1'b1;                                   // [R23]
        erase_err <= 1'b1;
      end else if (ev_clear) begin
        prog_err  <= 1'b0;                                   // [R11]
        erase_err <= 1'b0;
      end else if (ev_rej_prog) begin
        prog_err <= 1'b1;
      end else if (ev_rej_erase) begin
        erase_err <= 1'b1;
      end else if (op_done && state == ST_PROG && !prog_ok) begin
        prog_err <= 1'b1;                                    // [R14]
      end else if (op_done && state == ST_BLANK && !blank_ok) begin
        erase_err <= 1'b1;
      end
      if (op_done && state == ST_LOCKR) begin
        lock_data <= op_addr[FL_AW-1] ? 1'b1 : lock_bits[op_addr[5:4]];
      end
    end
  end

  // Program ROM lock bits; zero only by command, one by reset or erase.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_bits <= LOCK_RST;                                 // [R03]
    end else if (op_done && state == ST_LOCKP &&
                 !op_addr[FL_AW-1]) begin
      lock_bits[op_addr[5:4]] <= 1'b0;                       // [R05]
    end else if (erase_done && !erase_blk[2]) begin
      lock_bits[erase_blk[1:0]] <= 1'b1;                     // [R05] [R06]
    end
  end

  // Flash array; program can only clear bits, erase fills with FFh.
  always_ff @(posedge i_sys_clk) begin
    if (op_done && state == ST_PROG) begin
      mem[op_addr] <= mem[op_addr] & op_data;                // [R12]
    end
    if (erase_done) begin
      for (int i = 0; i < BLK_BYTES; i++) begin
        mem[{erase_blk, 4'(i)}] <= ERASED_BYTE;              // [R15]
      end
    end
  end

  // Array reads; a busy data flash lets only program ROM through.
  always_comb begin
    rd_blocked = 1'b0;
    if (state == ST_ERASE) begin
      rd_blocked = !erase_blk[2] || i_fl_req.addr[FL_AW-1];  // [R01] [R02]
    end else if (!ready_now) begin
      rd_blocked = !op_addr[FL_AW-1] || i_fl_req.addr[FL_AW-1];
    end else if (susp_held) begin
      rd_blocked = (blk_of(i_fl_req.addr) == erase_blk);
    end
  end

  // Read answer one cycle after the strobe; a refused read returns zero.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fl_rdata  <= 8'h00;
      o_fl_rvalid <= 1'b0;
      o_fl_rerr   <= 1'b0;
    end else begin
      o_fl_rvalid <= i_fl_req.rd;
      o_fl_rerr   <= i_fl_req.rd && rd_blocked;              // [R02]
      if (i_fl_req.rd && !rd_blocked) begin
        o_fl_rdata <= mem[i_fl_req.addr];                    // [R01] [R09]
      end else begin
        o_fl_rdata <= 8'h00;
      end
    end
  end

  // Control register 0.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl0 <= CTRL0_RST;
    end else if (i_reg_req.wr && i_reg_req.addr == REG_CTRL0) begin
      ctrl0 <= i_reg_req.wdata;
    end
  end

  // Control register 1; hardware clear of lock disable wins over writes.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl1      <= CTRL1_RST;
      ready_prev <= 1'b1;
    end else begin
      ready_prev <= ready_now;
      if (i_reg_req.wr && i_reg_req.addr == REG_CTRL1) begin
        ctrl1 <= i_reg_req.wdata;
      end
      if (erase_done || (ready_now && !ready_prev) || ev_seq_err ||
          abort) begin
        ctrl1[C1_LOCK_DIS] <= 1'b0;                          // [R07]
      end
    end
  end

  // Control register 2; interrupt-driven suspend request wins.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl2 <= CTRL2_RST;
    end else begin
      if (i_reg_req.wr && i_reg_req.addr == REG_CTRL2) begin
        ctrl2 <= i_reg_req.wdata;
      end
      if (state == ST_ERASE && ctrl2[C2_SUSP_BY_IRQ] && i_irq_req) begin
        ctrl2[C2_SUSP_REQ] <= 1'b1;                          // [R21]
      end
    end
  end

  // Register read port; data stand for one cycle only.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (!i_reg_req.rd) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.addr == REG_CTRL0) begin
      o_reg_rdata <= ctrl0;
    end else if (i_reg_req.addr == REG_CTRL1) begin
      o_reg_rdata <= ctrl1;
    end else if (i_reg_req.addr == REG_CTRL2) begin
      o_reg_rdata <= ctrl2;
    end else begin
      o_reg_rdata <= {ready_now, susp_held, erase_err, prog_err,
                      2'b00, lock_data, 1'b0};               // [R14]
    end
  end

  // Ready interrupt pulse on program or erase completion or on erase suspension.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ready_irq <= 1'b0;
    end else begin
      o_ready_irq <= ctrl0[C0_READY_IE] &&
                     ((op_done && state == ST_PROG) || erase_done ||
                      ev_suspend);                           // [R19] [R20]
    end
  end

  sequence s_prog_busy;
    (state == ST_PROG) [*8];
  endsequence

  bgo_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R01]
    (i_fl_req.rd && !i_fl_req.addr[6] &&
     ((state == ST_PROG && op_addr[6]) ||
      (state == ST_ERASE && erase_blk[2])))
    |=> (o_fl_rvalid && !o_fl_rerr))
    else $error("program ROM read refused during data flash busy");

  df_block_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R02]
    (i_fl_req.rd && state == ST_ERASE && erase_blk[2] && i_fl_req.addr[6])
    |=> o_fl_rerr)
    else $error("data flash read served while data flash busy");

  lock_guard_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R18]
    (state == ST_PEND && pend_cmd == CMD_PROGRAM && i_fl_req.wr && !abort
     && !susp_held && !i_fl_req.addr[6] && !ctrl1[C1_LOCK_DIS]
     && !lock_bits[i_fl_req.addr[5:4]])
    |=> (state == ST_IDLE && prog_err))
    else $error("locked block accepted a program");

  df_protect_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R17]
    (state == ST_PEND && pend_cmd == CMD_ERASE && i_fl_req.wr && !abort &&
     !susp_held && i_fl_req.wdata == CMD_CONFIRM && i_fl_req.addr[6] &&
     ctrl1[C1_BLK_DIS + 32'(i_fl_req.addr[5:4])])
    |=> (state != ST_ERASE && erase_err))
    else $error("rewrite-disabled block accepted an erase");

  prog_run_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R12]
    (state == ST_PEND && next_state == ST_PROG)
    |=> s_prog_busy ##[1:PROG_BOUND] (state != ST_PROG))
    else $error("program did not run for its time");

  seq_err_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R23]
    ev_seq_err |=> (prog_err && erase_err && !ctrl1[C1_LOCK_DIS]))
    else $error("sequence error did not set both error bits");

  clr_stat_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R11]
    ev_clear |=> (!prog_err && !erase_err))
    else $error("clear status left an error bit set");

  stop_lock_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R07]
    (ctrl0[C0_FLASH_STOP] && !(i_reg_req.wr && i_reg_req.addr == REG_CTRL0))
    |=> !ctrl1[C1_LOCK_DIS])
    else $error("lock disable survived flash stop");

  erase_lock_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R06]
    (erase_done && !erase_blk[2]) |=> lock_bits[$past(erase_blk[1:0])])
    else $error("erase did not set the lock bit");

  ready_irq_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R19]
    (erase_done && ctrl0[C0_READY_IE]) |=> o_ready_irq)
    else $error("no ready interrupt after erase");

  susp_irq_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R21]
    (state == ST_ERASE && ctrl2[C2_SUSP_BY_IRQ] && i_irq_req)
    |=> ctrl2[C2_SUSP_REQ])
    else $error("interrupt did not raise suspend request");

endmodule

// File: verif/fcs_cpu_model.sv
/*
  CPU bus model that issues byte reads and command writes to the flash.
  Assumes one system clock; the bench calls its tasks hierarchically.
*/
`timescale 1ns/1ps
module fcs_cpu_model (
  input  wire logic            i_sys_clk,
  input  wire logic [7:0]      i_fl_rdata,
  input  wire logic            i_fl_rvalid,
  input  wire logic            i_fl_rerr,
  output fcs_pkg::fcs_fl_req_s o_fl_req
);
  import fcs_pkg::*;
  initial o_fl_req = '0;
  // One byte write, strobe held for a single cycle.
  task automatic wr(input logic [FL_AW-1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_fl_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    o_fl_req.wr <= 1'b0;
  endtask
  // Two-cycle command, the same address in both cycles.
  task automatic cmd(input logic [7:0] c, input logic [FL_AW-1:0] a,
                     input logic [7:0] d);
    wr(a, c);
    wr(a, d);
  endtask
  // Byte read; missing answer shows as unknown data.
  task automatic rd(input logic [FL_AW-1:0] a, output logic [7:0] d,
                    output logic e);
    @(posedge i_sys_clk);
    o_fl_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    o_fl_req.rd <= 1'b0;
    #1 d = (i_fl_rvalid === 1'b1) ? i_fl_rdata : 8'hXX;
    e = i_fl_rerr;
  endtask
endmodule

// File: verif/tb_top.sv
/*
  Self-checking bench for the flash command sequencer.
  Assumes the CPU model in fcs_cpu_model and a 250 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import fcs_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        irq_req = 1'b0;
  fcs_fl_req_s  fl_req;
  fcs_reg_req_s reg_req = '0;
  logic [7:0]  fl_rdata, reg_rdata, v;
  logic        fl_rvalid, fl_rerr, ready_irq, e;
  int          miscompares = 0;
  int          comparisons = 0;
  int          irq_count   = 0;
  // Clock and ready interrupt pulse counter.
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (ready_irq === 1'b1) irq_count++;
  fcs_cpu_model cpu (.i_sys_clk(sys_clk), .i_fl_rdata(fl_rdata),
    .i_fl_rvalid(fl_rvalid), .i_fl_rerr(fl_rerr), .o_fl_req(fl_req));
  fcs_sequencer uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_fl_req(fl_req),
    .i_irq_req(irq_req), .i_reg_req(reg_req), .o_fl_rdata(fl_rdata),
    .o_fl_rvalid(fl_rvalid), .o_fl_rerr(fl_rerr),
    .o_reg_rdata(reg_rdata), .o_ready_irq(ready_irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Polls the status register until ready, then compares it.
  task automatic wait_ready(input logic [7:0] exp);
    int n;
    n = 0;
    v = 8'h00;
    while (v[ST_READY] !== 1'b1 && n < 1500) begin
      reg_rd(REG_STATUS, v);
      n++;
    end
    check(v, exp);
  endtask
  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog against a hung sequence.
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  // Main sequence of command scenarios.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    reg_rd(REG_STATUS, v); check(v, 8'h80);
    reg_wr(REG_CTRL0, 8'h81);
    cpu.cmd(CMD_ERASE, 7'h00, CMD_CONFIRM);
    reg_rd(REG_STATUS, v); check(v, 8'h00);
    wait_ready(8'h80);
    check(8'(irq_count), 8'h01);
    cpu.cmd(CMD_LOCK_READ, 7'h00, CMD_CONFIRM); wait_ready(8'h82);
    // The lock data bit keeps the result of the last lock status read.
    cpu.cmd(CMD_PROGRAM, 7'h05, 8'h5A); wait_ready(8'h82);
    cpu.rd(7'h05, v, e); check(v, 8'h5A);
    cpu.rd(7'h06, v, e); check(v, ERASED_BYTE);
    cpu.cmd(CMD_LOCK_PROG, 7'h00, CMD_CONFIRM); wait_ready(8'h82);
    cpu.cmd(CMD_LOCK_READ, 7'h00, CMD_CONFIRM); wait_ready(8'h80);
    cpu.cmd(CMD_PROGRAM, 7'h06, 8'h00); wait_ready(8'h90);
    check(8'(irq_count), 8'h02);
    cpu.wr(7'h00, CMD_CLEAR_STAT); wait_ready(8'h80);
    reg_wr(REG_CTRL1, 8'h08);
    cpu.cmd(CMD_ERASE, 7'h00, CMD_CONFIRM); wait_ready(8'h80);
    reg_rd(REG_CTRL1, v); check(v, 8'h00);
    cpu.cmd(CMD_LOCK_READ, 7'h00, CMD_CONFIRM); wait_ready(8'h82);
    cpu.cmd(CMD_ERASE, 7'h00, 8'h11); wait_ready(8'hB2);
    cpu.wr(7'h00, CMD_CLEAR_STAT);
    cpu.cmd(CMD_ERASE, 7'h40, CMD_CONFIRM);
    cpu.rd(7'h05, v, e); check({e, v[6:0]}, 8'h7F);
    cpu.rd(7'h50, v, e); check({7'h00, e}, 8'h01);
    wait_ready(8'h82);
    cpu.cmd(CMD_BLANK_CHECK, 7'h40, CMD_CONFIRM); wait_ready(8'h82);
    reg_wr(REG_CTRL1, 8'h10);
    cpu.cmd(CMD_ERASE, 7'h40, CMD_CONFIRM); wait_ready(8'hA2);
    cpu.wr(7'h00, CMD_CLEAR_STAT);
    reg_wr(REG_CTRL2, 8'h05);
    cpu.cmd(CMD_ERASE, 7'h10, CMD_CONFIRM);
    @(posedge sys_clk) irq_req <= 1'b1;
    @(posedge sys_clk) irq_req <= 1'b0;
    wait_ready(8'hC2);
    reg_rd(REG_CTRL2, v); check(v, 8'h07);
    check(8'(irq_count), 8'h05);
    reg_wr(REG_CTRL2, 8'h05);
    reg_rd(REG_STATUS, v); check(v, 8'h02);
    wait_ready(8'h82);
    // Flash stop must drop lock disable at once.
    reg_wr(REG_CTRL1, 8'h08);
    reg_rd(REG_CTRL1, v); check(v, 8'h08);
    reg_wr(REG_CTRL0, 8'h85);
    reg_rd(REG_CTRL1, v); check(v, 8'h00);
    final_report();
  end
endmodule
